// file: core/serial_out_pll_filter_cfg.sv
// Lane 3 emphasis, serializer PLL controls and FIR mode behind the serial port

module serial_out_pll_filter_cfg #(
  parameter int NTAPS = serial_out_pll_filter_cfg_pkg::NTAPS
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rstn,
  input  wire logic                             i_spi_csn,
  input  wire logic                             i_spi_sclk,
  input  wire logic                             i_spi_sdi,
  output logic                                  o_spi_sdo,
  output logic                                  o_spi_sdo_oe,
  input  wire logic                             i_pll_lock_lost,
  output logic                                  o_lane3_post_tap_en,
  output logic [2:0]                            o_lane3_post_tap_level,
  output logic                                  o_pll_cal_reset,
  output logic                                  o_pll_startup_reset,
  output logic                                  o_pll_startup_normal,
  output logic                                  o_pll_lock_loss_flag,
  output logic [2:0]                            o_fir_mode,
  input  wire logic [NTAPS-1:0][7:0]            i_coef_xi,
  input  wire logic [NTAPS-1:0][7:0]            i_coef_xq,
  input  wire logic [NTAPS-1:0][7:0]            i_coef_yi,
  input  wire logic [NTAPS-1:0][7:0]            i_coef_yq,
  input  wire logic                             i_in_valid,
  output logic                                  o_in_ready,
  input  wire serial_out_pll_filter_cfg_pkg::sample_t i_in_data,
  output logic                                  o_out_valid,
  input  wire logic                             i_out_ready,
  output serial_out_pll_filter_cfg_pkg::sample_t o_out_data
);
  localparam int SW    = serial_out_pll_filter_cfg_pkg::SAMPLE_W;
  localparam int CW    = serial_out_pll_filter_cfg_pkg::COEF_W;
  localparam int ACC_W = SW + CW + 4;
  localparam logic signed [ACC_W-1:0] SMAX = ACC_W'(2**(SW-1) - 1);
  localparam logic signed [ACC_W-1:0] SMIN = -SMAX - ACC_W'(1);
  localparam logic [NTAPS-1:0][CW-1:0] CZ = '0;
  localparam logic [NTAPS-1:0][SW-1:0] SZ = '0;

  typedef logic [NTAPS-1:0][CW-1:0]   coefs_t;
  typedef logic [2*NTAPS-1:0][SW-1:0] line_t;

  typedef struct packed {
    logic                 sclk_prev;
    logic [4:0]           cnt;
    logic [15:0]          shin;
    logic [15:0]          instr;
    logic                 rd_phase;
    logic [7:0]           rdsh;
    logic                 sdo;
    logic [7:0]           lane3_output_emphasis;
    logic [2:0]           fir_mode;
    logic [7:0]           serdes_pll_calibration;
    logic [7:0]           serdes_pll_startup_control;
    logic [7:0]           serdes_pll_lock_loss_control;
    logic                 lock_flag;
    coefs_t               ax_i;
    coefs_t               ax_q;
    coefs_t               ay_i;
    coefs_t               ay_q;
    line_t                dl_i;
    line_t                dl_q;
    logic [NTAPS-1:0][SW-1:0] cdl_i;
    logic [NTAPS-1:0][SW-1:0] cdl_q;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic        rise;
  logic        fall;
  logic        wr_stb;
  logic [14:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_val;
  logic        xfer;
  logic        lock_clr;
  logic        accept;
  logic        fifo_in_ready;
  line_t       ndl_i;
  line_t       ndl_q;
  logic [NTAPS-1:0][SW-1:0] ncdl_i;
  logic [NTAPS-1:0][SW-1:0] ncdl_q;
  logic signed [SW-1:0] xo_i;
  logic signed [SW-1:0] xo_q;
  serial_out_pll_filter_cfg_pkg::sample_t push_data;

  // Weighted sum over the tap line; tap 0 holds the newest sample
  function automatic logic signed [ACC_W-1:0] fir(
    input line_t                     dl,
    input logic [2*NTAPS-1:0][CW-1:0] c
  );
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    for (int k = 0; k < 2*NTAPS; k++)
      acc = acc + ACC_W'(signed'(dl[k]) * signed'(c[k]));
    return acc;
  endfunction

  // Coefficients are Q1.7, so drop seven bits and clip to sample range
  function automatic logic signed [SW-1:0] sat(
    input logic signed [ACC_W-1:0] a
  );
    logic signed [ACC_W-1:0] sh;
    sh = a >>> (CW - 1);
    if (sh > SMAX)
      sh = SMAX;
    else if (sh < SMIN)
      sh = SMIN;
    return sh[SW-1:0];
  endfunction

  // Read map; unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS:
        v = s_q.lane3_output_emphasis;
      serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL:
        v = {5'h00, s_q.fir_mode};  // Upper bits read as zero
      serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION:
        v = s_q.serdes_pll_calibration;
      serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP:
        v = s_q.serdes_pll_startup_control;
      serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS:
        v = s_q.serdes_pll_lock_loss_control;
      serial_out_pll_filter_cfg_pkg::ADDR_PLL_STATUS:
        v[serial_out_pll_filter_cfg_pkg::STATUS_LOCK_BIT] = s_q.lock_flag;
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction

  // Outputs decoded from held register values; data-out enable also needs chip select low
  assign o_spi_sdo              = s_q.sdo;
  assign o_spi_sdo_oe           = s_q.rd_phase & ~i_spi_csn;
  assign o_lane3_post_tap_en    = s_q.lane3_output_emphasis[7];
  assign o_lane3_post_tap_level = s_q.lane3_output_emphasis[6:4];
  assign o_pll_cal_reset        = (s_q.serdes_pll_calibration ==
                                   serial_out_pll_filter_cfg_pkg::CAL_RESTART);
  assign o_pll_startup_reset    = (s_q.serdes_pll_startup_control ==
                                   serial_out_pll_filter_cfg_pkg::STARTUP_HOLD);
  assign o_pll_startup_normal   = (s_q.serdes_pll_startup_control ==
                                   serial_out_pll_filter_cfg_pkg::STARTUP_NORMAL);
  assign o_pll_lock_loss_flag   = s_q.lock_flag;
  assign o_fir_mode             = s_q.fir_mode;
  assign accept                 = i_in_valid & fifo_in_ready;
  assign o_in_ready             = fifo_in_ready;

  // Serial port, register writes and the filter datapath
  always_comb
  begin
    s_d = s_q;
    rd_val = 8'h00;
    wr_stb = 1'b0;
    wr_addr = s_q.instr[14:0];
    wr_data = {s_q.shin[6:0], i_spi_sdi};
    xfer = 1'b0;
    lock_clr = 1'b0;
    rise = ~i_spi_csn & i_spi_sclk & ~s_q.sclk_prev;
    fall = ~i_spi_csn & ~i_spi_sclk & s_q.sclk_prev;
    s_d.sclk_prev = i_spi_sclk;
    if (i_spi_csn)
    begin
      s_d.cnt = 5'h00;
      s_d.rd_phase = 1'b0;
    end
    else if (rise)
    begin
      s_d.shin = {s_q.shin[14:0], i_spi_sdi};
      if (s_q.cnt != serial_out_pll_filter_cfg_pkg::FRAME_BITS)
        s_d.cnt = s_q.cnt + 5'h01;
      // Instruction complete: read data is fetched now, MSB first
      if (s_q.cnt == serial_out_pll_filter_cfg_pkg::INSTR_BITS - 5'h01)
      begin
        s_d.instr = {s_q.shin[14:0], i_spi_sdi};
        rd_val = read_reg(s_d.instr[14:0]);
        s_d.rd_phase = s_d.instr[serial_out_pll_filter_cfg_pkg::RW_BIT];
        s_d.sdo = rd_val[7];
        s_d.rdsh = {rd_val[6:0], 1'b0};
      end
      if (s_q.cnt == serial_out_pll_filter_cfg_pkg::FRAME_BITS - 5'h01 &&
          !s_q.instr[serial_out_pll_filter_cfg_pkg::RW_BIT])
        wr_stb = 1'b1;
    end
    else if (fall && s_q.rd_phase &&
             s_q.cnt > serial_out_pll_filter_cfg_pkg::INSTR_BITS &&
             s_q.cnt < serial_out_pll_filter_cfg_pkg::FRAME_BITS)
    begin
      s_d.sdo = s_q.rdsh[7];
      s_d.rdsh = {s_q.rdsh[6:0], 1'b0};
    end

    // Register writes; filter control reserved bits are simply not stored, chip transfer only pulses, other registers keep all eight bits
    if (wr_stb)
    begin
      case (wr_addr)
        serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS:
          s_d.lane3_output_emphasis = wr_data;
        serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL:
          s_d.fir_mode = wr_data[2:0];
        serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION:
          s_d.serdes_pll_calibration = wr_data;
        serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP:
          s_d.serdes_pll_startup_control = wr_data;
        serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS:
        begin
          s_d.serdes_pll_lock_loss_control = wr_data;
          lock_clr = (wr_data ==
                      serial_out_pll_filter_cfg_pkg::LOCK_LOSS_CLEAR);
        end
        serial_out_pll_filter_cfg_pkg::ADDR_CHIP_TRANSFER:
          xfer = wr_data[serial_out_pll_filter_cfg_pkg::XFER_BIT];
        default:
          xfer = 1'b0;
      endcase
    end

    // A new loss of lock beats a clear in the same cycle
    s_d.lock_flag = (s_q.lock_flag & ~lock_clr) | i_pll_lock_lost;

    // Staged coefficients reach the filter only on chip transfer
    if (xfer)
    begin
      s_d.ax_i = i_coef_xi;
      s_d.ax_q = i_coef_xq;
      s_d.ay_i = i_coef_yi;
      s_d.ay_q = i_coef_yq;
    end

    // Filter X output feeds the cascade line
    ndl_i = {s_q.dl_i[2*NTAPS-2:0], i_in_data.i};
    ndl_q = {s_q.dl_q[2*NTAPS-2:0], i_in_data.q};
    xo_i = sat(fir(ndl_i, {CZ, s_q.ax_i}));
    xo_q = sat(fir(ndl_q, {CZ, s_q.ax_q}));
    ncdl_i = {s_q.cdl_i[NTAPS-2:0], xo_i};
    ncdl_q = {s_q.cdl_q[NTAPS-2:0], xo_q};
    push_data = i_in_data;
    case (serial_out_pll_filter_cfg_pkg::fir_mode_t'(s_q.fir_mode))
      serial_out_pll_filter_cfg_pkg::FIR_BYPASS:
        push_data = i_in_data;
      serial_out_pll_filter_cfg_pkg::FIR_SINGLE_X:
      begin
        push_data.i = xo_i;
        push_data.q = xo_q;
      end
      serial_out_pll_filter_cfg_pkg::FIR_JOINED_XY:
      begin
        push_data.i = sat(fir(ndl_i, {s_q.ay_i, s_q.ax_i}));
        push_data.q = sat(fir(ndl_q, {s_q.ay_q, s_q.ax_q}));
      end
      serial_out_pll_filter_cfg_pkg::FIR_CASCADE:
      begin
        push_data.i = sat(fir({SZ, ncdl_i}, {CZ, s_q.ay_i}));
        push_data.q = sat(fir({SZ, ncdl_q}, {CZ, s_q.ay_q}));
      end
      serial_out_pll_filter_cfg_pkg::FIR_COMPLEX:
      begin
        push_data.i = sat(fir(ndl_i, {CZ, s_q.ax_i}) +
                          fir(ndl_q, {CZ, s_q.ay_q}));
        push_data.q = sat(fir(ndl_q, {CZ, s_q.ax_q}) +
                          fir(ndl_i, {CZ, s_q.ay_i}));
      end
      default:
        push_data = i_in_data;  // Reserved codes pass samples
    endcase
    if (accept)
    begin
      s_d.dl_i = ndl_i;
      s_d.dl_q = ndl_q;
      s_d.cdl_i = ncdl_i;
      s_d.cdl_q = ncdl_q;
    end
  end

  // State register with documented reset values
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.lane3_output_emphasis <= serial_out_pll_filter_cfg_pkg::EMPH_RST;
      s_q.fir_mode <= serial_out_pll_filter_cfg_pkg::MODE_RST;
      s_q.serdes_pll_calibration <= serial_out_pll_filter_cfg_pkg::CAL_RST;
      s_q.serdes_pll_startup_control <=
        serial_out_pll_filter_cfg_pkg::STARTUP_RST;
      s_q.serdes_pll_lock_loss_control <=
        serial_out_pll_filter_cfg_pkg::LOCK_RST;
    end
    else
      s_q <= s_d;
  end

  // Output buffer; its ready is the back-pressure seen by the source
  sample_fifo #(
    .WIDTH ($bits(serial_out_pll_filter_cfg_pkg::sample_t)),
    .DEPTH (serial_out_pll_filter_cfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (accept),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_data),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  (o_out_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_write(logic [14:0] a);
    wr_stb && wr_addr == a;
  endsequence

  sequence s_lock_clear;
    s_write(serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS) and
    (wr_data == serial_out_pll_filter_cfg_pkg::LOCK_LOSS_CLEAR);
  endsequence

  a_emph_write: assert property (
    s_write(serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS) |=>
    o_lane3_post_tap_en == $past(wr_data[7]) &&
    o_lane3_post_tap_level == $past(wr_data[6:4]))
    else $error("lane 3 emphasis fields not taken");
  a_cal_restart: assert property (
    s_write(serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION) and
    (wr_data == serial_out_pll_filter_cfg_pkg::CAL_RESTART) |=>
    o_pll_cal_reset)
    else $error("calibration restart not driven");
  a_startup_hold: assert property (
    s_write(serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP) and
    (wr_data == serial_out_pll_filter_cfg_pkg::STARTUP_HOLD) |=>
    o_pll_startup_reset && !o_pll_startup_normal)
    else $error("start-up circuit not held in reset");
  a_lock_clear: assert property (
    s_lock_clear and !i_pll_lock_lost |=> !o_pll_lock_loss_flag)
    else $error("lock-loss flag not cleared");
  a_lock_set_wins: assert property (
    i_pll_lock_lost |=> o_pll_lock_loss_flag [*1] ##1
    (o_pll_lock_loss_flag || $past(lock_clr)))
    else $error("lock-loss event lost");
  a_mode_reserved: assert property (
    s_write(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL) |=>
    o_fir_mode == $past(wr_data[2:0]) &&
    (read_reg(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL) &
     8'hf8) == 8'h00)
    else $error("filter control reserved bits not zero");
  a_bypass_pass: assert property (
    accept && s_q.fir_mode == 3'h0 |-> push_data == i_in_data)
    else $error("bypass changed the sample");
  a_cascade_feed: assert property (
    accept |=> s_q.cdl_i[0] == $past(xo_i) && s_q.dl_i[0] ==
    $past(i_in_data.i))
    else $error("cascade line not fed by filter X");
  a_coef_hold: assert property (
    !$stable(s_q.ax_i) |-> $past(xfer))
    else $error("coefficients changed without transfer");
  a_fifo_stall: assert property (
    !fifo_in_ready |=> $stable(s_q.dl_i) && $stable(s_q.cdl_i))
    else $error("sample taken while buffer full");

endmodule

// file: core/serial_out_pll_filter_cfg_pkg.sv
// Shared constants and types for the configuration slice
package serial_out_pll_filter_cfg_pkg;

  // Datapath sizes
  localparam int SAMPLE_W   = 16;
  localparam int COEF_W     = 8;
  localparam int NTAPS      = 4;
  localparam int FIFO_DEPTH = 8;

  // Register offsets on the serial control port (15-bit address)
  localparam logic [14:0] ADDR_CHIP_TRANSFER    = 15'h000f;
  localparam logic [14:0] ADDR_LANE3_EMPHASIS   = 15'h05ca;
  localparam logic [14:0] ADDR_FIR_CONTROL      = 15'h0df8;
  localparam logic [14:0] ADDR_PLL_CALIBRATION  = 15'h1222;
  localparam logic [14:0] ADDR_PLL_STARTUP      = 15'h1228;
  localparam logic [14:0] ADDR_PLL_LOCK_LOSS    = 15'h1262;
  localparam logic [14:0] ADDR_PLL_STATUS       = 15'h1264;

  // Field positions
  localparam int EMPH_EN_BIT     = 7;
  localparam int EMPH_LVL_LSB    = 4;
  localparam int EMPH_LVL_W      = 3;
  localparam int MODE_W          = 3;
  localparam int XFER_BIT        = 0;
  localparam int STATUS_LOCK_BIT = 0;

  // Reset values
  localparam logic [7:0]        EMPH_RST    = 8'h00;
  localparam logic [7:0]        CAL_RST     = 8'h00;
  localparam logic [7:0]        STARTUP_RST = 8'h0f;
  localparam logic [7:0]        LOCK_RST    = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST    = 3'h0;

  // Command values
  localparam logic [7:0] CAL_RESTART     = 8'h04;
  localparam logic [7:0] STARTUP_HOLD    = 8'h4f;
  localparam logic [7:0] STARTUP_NORMAL  = 8'h00;
  localparam logic [7:0] LOCK_LOSS_CLEAR = 8'h80;

  // Serial frame: 16 instruction bits then 8 data bits
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int         RW_BIT     = 15;

  typedef enum logic [2:0] {
    FIR_BYPASS    = 3'b000,
    FIR_SINGLE_X  = 3'b001,
    FIR_JOINED_XY = 3'b010,
    FIR_CASCADE   = 3'b100,
    FIR_COMPLEX   = 3'b101
  } fir_mode_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } sample_t;

endpackage

// file: core/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Extra pointer bit tells full from empty; DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic [AW:0] count;
  logic        push;
  logic        pop;

  // Flags come straight from the pointers
  assign count       = s_q.wp - s_q.rp;
  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = s_q.mem[s_q.rp[AW-1:0]];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Next state: write at the tail, read from the head
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp[AW-1:0]] = i_in_data;
      s_d.wp = s_q.wp + (AW+1)'(1);
    end
    if (pop)
    begin
      s_d.rp = s_q.rp + (AW+1)'(1);
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule

// file: verif/spi_host_model.sv
// Host-side serial control port model that drives frames into the block
module spi_host_model (
  input  wire logic  i_clk,
  input  wire logic  i_sdo,
  output logic       o_csn,
  output logic       o_sclk,
  output logic       o_sdi,
  output logic [7:0] o_rd_data,
  output logic       o_rd_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: deselected, serial clock parked low
  initial
  begin
    o_csn = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_rd_data = 8'h00;
    o_rd_done = 1'b0;
  end

  // One 24-bit frame, MSB first; four system clocks per sclk level
  // so the block's edge detector always has margin
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [7:0] wd);
    logic [23:0] f;
    int          n;
    f = {rd, a, wd};
    @(negedge i_clk);
    o_csn = 1'b0;
    for (n = 23; n >= 0; n--)
    begin
      o_sdi = f[n];
      repeat (4) @(negedge i_clk);
      if (n < 8)
        o_rd_data[n] = i_sdo; // Read data is taken just before the rise
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_csn = 1'b1;
    o_sdi = ~o_sdi; // Released line must not keep the last bit
    o_rd_done = rd;
    @(negedge i_clk);
    o_rd_done = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench: registers over the serial port plus sample stream
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic             i_clk, i_rstn, csn, sclk, sdi, sdo, sdo_oe, sdo_line;
  logic             lock_lost, tap_en, cal_rst, su_rst, su_norm, lol_flag;
  logic [2:0]       tap_lvl, fir_mode, cur_mode;
  logic [3:0][7:0]  c_xi, c_xq, c_yi, c_yq;
  logic             in_valid, in_ready, out_valid, out_ready, rd_done;
  logic [7:0]       rd_data, v;
  serial_out_pll_filter_cfg_pkg::sample_t in_data, out_data, sq[$], hist[$];
  logic [7:0]       rq[$];
  logic [2:0]       ml[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  logic [2:0]       sm[6] = '{3'h1, 3'h4, 3'h2, 3'h5, 3'h3, 3'h0};
  int               error_cnt, checks, k, n;

  // Undriven data-out shows the inverse, so a late enable breaks the read
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  serial_out_pll_filter_cfg #(.NTAPS(4)) serial_out_pll_filter_cfg_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_spi_csn(csn), .i_spi_sclk(sclk),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
    .i_pll_lock_lost(lock_lost), .o_lane3_post_tap_en(tap_en),
    .o_lane3_post_tap_level(tap_lvl), .o_pll_cal_reset(cal_rst),
    .o_pll_startup_reset(su_rst), .o_pll_startup_normal(su_norm),
    .o_pll_lock_loss_flag(lol_flag), .o_fir_mode(fir_mode),
    .i_coef_xi(c_xi), .i_coef_xq(c_xq), .i_coef_yi(c_yi), .i_coef_yq(c_yq),
    .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_data(in_data),
    .o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_data(out_data));

  spi_host_model spi_host_model_inst (
    .i_clk(i_clk), .i_sdo(sdo_line), .o_csn(csn), .o_sclk(sclk),
    .o_sdi(sdi), .o_rd_data(rd_data), .o_rd_done(rd_done));

  // 50 MHz system clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi_host_model_inst.xfer(1'b0, a, d);
  endtask

  // The expected byte is noted before the frame; the watcher compares
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    rq.push_back(e);
    spi_host_model_inst.xfer(1'b1, a, 8'h00);
  endtask

  // Reference filter for tap-0-only coefficient sets; the joined filter
  // also sees the sample taken four before, through filter Y's tap 0
  function automatic serial_out_pll_filter_cfg_pkg::sample_t expf(
    input serial_out_pll_filter_cfg_pkg::sample_t d);
    serial_out_pll_filter_cfg_pkg::sample_t r;
    serial_out_pll_filter_cfg_pkg::sample_t o;
    r = d;
    o = (hist.size() >= 4) ? hist[hist.size() - 4] : '0;
    case (cur_mode)
      3'h2:
      begin
        r.i = 16'((int'(d.i) + int'(o.i)) >>> 1);
        r.q = 16'((int'(d.q) + 2 * int'(o.q)) >>> 2);
      end
      3'h5:
      begin
        r.i = 16'((int'(d.i) + int'(d.q)) >>> 1);
        r.q = 16'((int'(d.q) + 2 * int'(d.i)) >>> 2);
      end
      3'h1:
      begin
        r.i = d.i >>> 1;
        r.q = d.q >>> 2;
      end
      3'h4:
      begin
        r.i = d.i >>> 2;
        r.q = d.q >>> 3;
      end
      default: r = d;
    endcase
    return r;
  endfunction

  // Offer one random sample; note the expected output if it was taken
  task automatic send(output logic taken);
    @(negedge i_clk);
    in_valid = 1'b1;
    in_data = $urandom;
    #1;
    taken = in_ready;
    if (taken === 1'b1)
    begin
      sq.push_back(expf(in_data));
      hist.push_back(in_data);
    end
  endtask

  task automatic drain;
    @(negedge i_clk);
    in_valid = 1'b0;
    out_ready = 1'b1;
    for (n = 0; n < 20 && out_valid !== 1'b0; n++)
      @(negedge i_clk);
    chk(sq.size(), 0);
  endtask

  // Watcher: every delivered sample and every read byte meets its note;
  // it looks after the falling edge, clear of the launching rising edge
  always @(negedge i_clk)
  begin
    #1;
    if (out_valid === 1'b1 && out_ready === 1'b1)
      chk(out_data, (sq.size() > 0) ? sq.pop_front() : ~out_data);
    if (rd_done === 1'b1)
      chk(rd_data, (rq.size() > 0) ? rq.pop_front() : ~rd_data);
  end

  // Watchdog: the sequence needs well under 40k clocks
  initial
  begin
    #1_500_000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    i_rstn = 1'b0;
    lock_lost = 1'b0;
    in_valid = 1'b0;
    in_data = '0;
    out_ready = 1'b0;
    cur_mode = 3'h0;
    c_xi = {24'h000000, 8'h40};
    c_xq = {24'h000000, 8'h20};
    c_yi = {24'h000000, 8'h40};
    c_yq = {24'h000000, 8'h40};
    error_cnt = 0;
    checks = 0;
    void'($urandom(82));
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    chk({su_rst, su_norm, lol_flag, cal_rst}, 4'h0);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS, 8'h00);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL, 8'h00);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION, 8'h00);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP, 8'h0f);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS, 8'h00);
    rd(15'h0123, 8'h00);
    $display("test reset values done");
    // Post-tap level codes 0 to 4 with a random enable and reserved nibble
    for (k = 0; k < 5; k++)
    begin
      v = {1'($urandom), k[2:0], 4'($urandom)};
      wr(serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS, v);
      chk({tap_en, tap_lvl}, v[7:4]);
      rd(serial_out_pll_filter_cfg_pkg::ADDR_LANE3_EMPHASIS, v);
    end
    $display("test emphasis done");
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION, 8'h04);
    chk(cal_rst, 1'b1);
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_CALIBRATION, 8'h00);
    chk(cal_rst, 1'b0);
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP, 8'h4f);
    chk({su_rst, su_norm}, 2'b10);
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_STARTUP, 8'h00);
    chk({su_rst, su_norm}, 2'b01);
    @(negedge i_clk);
    lock_lost = 1'b1;
    @(negedge i_clk);
    lock_lost = 1'b0;
    chk(lol_flag, 1'b1);
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS, 8'h00);
    chk(lol_flag, 1'b1);
    wr(serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS, 8'h80);
    chk(lol_flag, 1'b0);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_PLL_LOCK_LOSS, 8'h80);
    $display("test pll controls done");
    wr(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL, 8'hf9);
    rd(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL, 8'h01);
    for (k = 0; k < 5; k++)
    begin
      wr(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL, {5'h00, ml[k]});
      chk(fir_mode, ml[k]);
    end
    // Load the impulse set, then stage a different one left unapplied
    wr(serial_out_pll_filter_cfg_pkg::ADDR_CHIP_TRANSFER, 8'h01);
    c_xi = {4{8'h7f}};
    c_xq = {4{8'h7f}};
    c_yi = {4{8'h7f}};
    c_yq = {4{8'h7f}};
    for (k = 0; k < 6; k++)
    begin
      cur_mode = sm[k];
      wr(serial_out_pll_filter_cfg_pkg::ADDR_FIR_CONTROL, {5'h00, cur_mode});
      out_ready = (k != 5);
      for (n = 0; n < 12; n++)
        send(v[0]);
      if (k == 5)
        chk(sq.size(), 8);
      drain();
    end
    $display("test filter stream done");
    end_sim();
  end
endmodule
